// ==== hw/pplc_pkg.sv ====
package pplc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] RUN_POWER_CONFIG_ADDR = 32'h40048238;
    localparam logic [31:0] PART_IDENTITY_ADDR    = 32'h400483F8;
    localparam logic [31:0] PLL_CONTROL_ADDR      = 32'h40048400;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CRYSTAL_BIT      = 5;
    localparam int          WATCHDOG_BIT     = 6;
    localparam int          PLL_BIT          = 7;
    localparam int          COMPARATOR_BIT   = 15;
    localparam int          RSV_LO_POS       = 8;
    localparam int          RSV_HI_POS       = 12;
    localparam logic [3:0]  RSV_LO_RESET     = 4'hD;
    localparam logic [2:0]  RSV_HI_RESET     = 3'h6;
    localparam logic        POWERDOWN_RESET  = 1'b1;
    localparam int          FB_SEL_POS       = 0;
    localparam int          POST_SEL_POS     = 5;
    localparam int          BYPASS_BIT       = 7;
    localparam logic [4:0]  FB_SEL_RESET     = 5'h00;
    localparam logic [1:0]  POST_SEL_RESET   = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ          = 10;
    localparam int          LOCK_CRIT_NS     = 200;
    localparam int          LOCK_CRIT_CYC    = (LOCK_CRIT_NS * CLK_MHZ) / 1000;
    localparam int          LOCK_COUNT       = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic crystal_osc_powerdown;
        logic watchdog_osc_powerdown;
        logic pll_powerdown;
        logic comparator_powerdown;
    } pplc_pwr_t;

    typedef struct packed {
        logic [1:0] post_div_select;
        logic [4:0] feedback_div_select;
        logic       bypass;
    } pplc_div_t;

endpackage

// ==== hw/pplc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pplc_top #(
    parameter logic [31:0] PART_CODE = 32'h0000_A5A5  // Arbitrary value
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [31:0]       addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [31:0]            rdata,
    input  wire logic              wdt_lock,
    input  wire logic              ref_clk_in,
    input  wire logic              osc_clk_in,
    output pplc_pkg::pplc_pwr_t    pwr,
    output logic                   pll_analog_en,
    output logic                   main_clk_out,
    output logic                   pll_lock
);
    import pplc_pkg::*;

    // Criterion must fit below the saturating edge counter
    if (LOCK_CRIT_CYC < 1 || LOCK_CRIT_CYC > 14) begin : g_crit_check
        $error("Lock criterion outside counter range");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    pplc_pwr_t   pwr_ff;
    logic [3:0]  rsv_lo_ff;
    logic [2:0]  rsv_hi_ff;
    pplc_div_t   div_ff;
    logic [31:0] rdata_ff;

    logic wr_cfg;
    logic wr_pll;
    assign wr_cfg = wr && (addr == RUN_POWER_CONFIG_ADDR);
    assign wr_pll = wr && (addr == PLL_CONTROL_ADDR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_ff    <= '{POWERDOWN_RESET, POWERDOWN_RESET,
                           POWERDOWN_RESET, POWERDOWN_RESET};
            rsv_lo_ff <= RSV_LO_RESET;
            rsv_hi_ff <= RSV_HI_RESET;
        end else if (wr_cfg) begin
            pwr_ff.crystal_osc_powerdown  <= wdata[CRYSTAL_BIT];
            pwr_ff.pll_powerdown          <= wdata[PLL_BIT];
            pwr_ff.comparator_powerdown   <= wdata[COMPARATOR_BIT];
            pwr_ff.watchdog_osc_powerdown <= wdata[WATCHDOG_BIT] && !wdt_lock;
            rsv_lo_ff <= wdata[RSV_LO_POS +: 4];
            rsv_hi_ff <= wdata[RSV_HI_POS +: 3];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff <= '{POST_SEL_RESET, FB_SEL_RESET, 1'b0};
        end else if (wr_pll) begin
            div_ff.feedback_div_select <= wdata[FB_SEL_POS +: 5];
            div_ff.post_div_select     <= wdata[POST_SEL_POS +: 2];
            div_ff.bypass              <= wdata[BYPASS_BIT];
        end
    end

    logic [31:0] cfg_word;
    logic [31:0] pll_word;
    always_comb begin
        cfg_word = 32'h00000000;
        cfg_word[CRYSTAL_BIT]       = pwr_ff.crystal_osc_powerdown;
        cfg_word[WATCHDOG_BIT]      = pwr_ff.watchdog_osc_powerdown;
        cfg_word[PLL_BIT]           = pwr_ff.pll_powerdown;
        cfg_word[COMPARATOR_BIT]    = pwr_ff.comparator_powerdown;
        cfg_word[RSV_LO_POS +: 4]   = rsv_lo_ff;
        cfg_word[RSV_HI_POS +: 3]   = rsv_hi_ff;
        pll_word = 32'h00000000;
        pll_word[FB_SEL_POS +: 5]   = div_ff.feedback_div_select;
        pll_word[POST_SEL_POS +: 2] = div_ff.post_div_select;
        pll_word[BYPASS_BIT]        = div_ff.bypass;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                RUN_POWER_CONFIG_ADDR: rdata_ff <= cfg_word;
                PART_IDENTITY_ADDR:    rdata_ff <= PART_CODE;
                PLL_CONTROL_ADDR:      rdata_ff <= pll_word;
                default:               rdata_ff <= 32'h00000000;
            endcase
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign rdata = rdata_ff;

    logic pll_pd;
    assign pll_pd = pwr_ff.pll_powerdown;

    always_comb begin
        pwr = pwr_ff;
        pwr.watchdog_osc_powerdown = pwr_ff.watchdog_osc_powerdown && !wdt_lock;
    end

    assign pll_analog_en = !pll_pd;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] ref_sync_ff;
    logic [2:0] osc_sync_ff;
    logic       ref_lvl_ff;
    logic       osc_lvl_ff;
    logic       ref_rise;
    logic       osc_rise;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_sync_ff <= 3'h0;
            osc_sync_ff <= 3'h0;
        end else begin
            ref_sync_ff <= {ref_sync_ff[1:0], ref_clk_in};
            osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_in};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_lvl_ff <= 1'b0;
            osc_lvl_ff <= 1'b0;
        end else begin
            if (ref_sync_ff[1] == ref_sync_ff[2]) begin
                ref_lvl_ff <= ref_sync_ff[2];
            end
            if (osc_sync_ff[1] == osc_sync_ff[2]) begin
                osc_lvl_ff <= osc_sync_ff[2];
            end
        end
    end

    assign ref_rise = ref_sync_ff[1] && ref_sync_ff[2] && !ref_lvl_ff;
    assign osc_rise = osc_sync_ff[1] && osc_sync_ff[2] && !osc_lvl_ff && !pll_pd;

    // ------------------------------------------------------------
    // Post divider
    // ------------------------------------------------------------
    logic [3:0] post_cnt_ff;
    logic [3:0] p_last;
    logic       post_tgl_ff;
    logic       main_clk_ff;

    assign p_last = 4'((4'h1 << div_ff.post_div_select) - 4'h1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            post_cnt_ff <= 4'h0;
            post_tgl_ff <= 1'b0;
        end else if (pll_pd) begin
            post_cnt_ff <= 4'h0;
            post_tgl_ff <= 1'b0;
        end else if (osc_rise) begin
            if (post_cnt_ff == p_last) begin
                post_cnt_ff <= 4'h0;
                post_tgl_ff <= !post_tgl_ff;
            end else begin
                post_cnt_ff <= post_cnt_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_clk_ff <= 1'b0;
        end else if (pll_pd) begin
            main_clk_ff <= 1'b0;
        end else begin
            main_clk_ff <= div_ff.bypass ? osc_lvl_ff : post_tgl_ff;
        end
    end

    assign main_clk_out = main_clk_ff;

    // ------------------------------------------------------------
    // Feedback divider
    // ------------------------------------------------------------
    logic       main_prev_ff;
    logic [4:0] fb_cnt_ff;
    logic       main_rise;
    logic       fb_rise;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_prev_ff <= 1'b0;
        end else begin
            main_prev_ff <= main_clk_ff;
        end
    end

    assign main_rise = main_clk_ff && !main_prev_ff && !pll_pd;
    assign fb_rise   = main_rise && (fb_cnt_ff == div_ff.feedback_div_select);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fb_cnt_ff <= 5'h00;
        end else if (pll_pd) begin
            fb_cnt_ff <= 5'h00;
        end else if (main_rise) begin
            fb_cnt_ff <= fb_rise ? 5'h00 : fb_cnt_ff + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Lock detector
    // ------------------------------------------------------------
    localparam logic [3:0] CRIT  = 4'(LOCK_CRIT_CYC);
    localparam logic [3:0] SATUR = 4'(LOCK_COUNT + 1);

    logic [3:0] since_fb_ff;
    logic [3:0] wait_ff;
    logic       pend_ff;
    logic [3:0] match_cnt_ff;
    logic       lock_ff;
    logic       cmp_ok;
    logic       cmp_bad;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_fb_ff <= 4'hF;
        end else if (pll_pd || fb_rise) begin
            since_fb_ff <= pll_pd ? 4'hF : 4'h0;
        end else if (since_fb_ff != 4'hF) begin
            since_fb_ff <= since_fb_ff + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_ff <= 1'b0;
            wait_ff <= 4'h0;
        end else if (pll_pd) begin
            pend_ff <= 1'b0;
            wait_ff <= 4'h0;
        end else if (ref_rise && !fb_rise && since_fb_ff > CRIT) begin
            pend_ff <= 1'b1;
            wait_ff <= 4'h0;
        end else if (pend_ff) begin
            pend_ff <= !(fb_rise || wait_ff == CRIT);
            wait_ff <= wait_ff + 4'h1;
        end
    end

    always_comb begin
        cmp_ok  = 1'b0;
        cmp_bad = 1'b0;
        if (!pll_pd) begin
            if (pend_ff) begin
                cmp_ok  = fb_rise;
                cmp_bad = !fb_rise && (wait_ff == CRIT);
            end else if (ref_rise) begin
                cmp_ok  = fb_rise || (since_fb_ff <= CRIT);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_cnt_ff <= 4'h0;
        end else if (pll_pd || cmp_bad) begin
            match_cnt_ff <= 4'h0;
        end else if (cmp_ok && match_cnt_ff != SATUR) begin
            match_cnt_ff <= match_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_ff <= 1'b0;
        end else if (pll_pd || cmp_bad) begin
            lock_ff <= 1'b0;
        end else if (cmp_ok && match_cnt_ff == 4'(LOCK_COUNT)) begin
            lock_ff <= 1'b1;
        end
    end

    assign pll_lock = lock_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_last_good;
        cmp_ok && !cmp_bad && !pll_pd && match_cnt_ff == 4'(LOCK_COUNT);
    endsequence

    sequence s_miss;
        cmp_bad && !pll_pd;
    endsequence

    AST_PD_NO_LOCK: assert property (@(posedge clk) disable iff (rst)
        pll_pd |=> !pll_lock)
        else $error("Lock high during PLL power-down");

    AST_WDT_KEPT: assert property (@(posedge clk) disable iff (rst)
        wdt_lock |-> !pwr.watchdog_osc_powerdown)
        else $error("Watchdog oscillator stopped while locked");

    AST_ID_READ: assert property (@(posedge clk) disable iff (rst)
        rd && addr == PART_IDENTITY_ADDR |=> rdata == PART_CODE)
        else $error("Part identity read wrong");

    AST_LOCK_CAUSE: assert property (@(posedge clk) disable iff (rst)
        $rose(pll_lock) |-> $past(match_cnt_ff) == 4'(LOCK_COUNT) && $past(cmp_ok))
        else $error("Lock rose without enough matches");

    AST_MISS_CLEARS: assert property (@(posedge clk) disable iff (rst)
        s_miss |=> !pll_lock && match_cnt_ff == 4'h0)
        else $error("Bad comparison did not clear lock");

    AST_DIV_RESET: assert property (@(posedge clk) disable iff (rst)
        pll_pd |=> post_cnt_ff == 4'h0 && fb_cnt_ff == 5'h00 && !main_clk_out)
        else $error("Dividers not held in reset");

    AST_WRITE_NOW: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> pwr.pll_powerdown == $past(wdata[PLL_BIT])
            && pwr.crystal_osc_powerdown == $past(wdata[CRYSTAL_BIT])
            && pwr.comparator_powerdown == $past(wdata[COMPARATOR_BIT]))
        else $error("Power write not applied at once");

    AST_LOCK_RISE: assert property (@(posedge clk) disable iff (rst)
        s_last_good |=> pll_lock && match_cnt_ff == SATUR)
        else $error("Lock missing after ninth match");

    AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (rst)
        pll_lock && !cmp_bad && !pll_pd |=> pll_lock)
        else $error("Lock dropped without cause");

    AST_POST_RATIO: assert property (@(posedge clk) disable iff (rst)
        $changed(post_tgl_ff) && !pll_pd && !$past(pll_pd)
            |-> $past(post_cnt_ff) == $past(p_last))
        else $error("Post divider toggled off count");

    AST_FB_RATIO: assert property (@(posedge clk) disable iff (rst)
        main_rise && !fb_rise |=> fb_cnt_ff == $past(fb_cnt_ff) + 5'h01)
        else $error("Feedback divider count wrong");

endmodule
`default_nettype wire

// ==== verification/tb_pll_power_and_lock_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_pll_power_and_lock_control;
    import pplc_pkg::*;

    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    localparam logic [31:0] TB_PART_CODE  = 32'h0000_3C96;  // Arbitrary value
    localparam logic [31:0] UNMAPPED_ADDR = 32'h4004_8000;
    localparam logic [31:0] CFG           = RUN_POWER_CONFIG_ADDR;

    typedef struct packed {
        logic [31:0] wdata;
        logic [31:0] rd;
        logic [3:0]  pwr;
        logic        en;
    } pplc_row_t;

    localparam pplc_row_t ROWS [6] = '{
        '{32'h0000_6D00, 32'h0000_6D00, 4'h0, 1'b1},
        '{32'h0000_6D20, 32'h0000_6D20, 4'h8, 1'b1},
        '{32'h0000_6D40, 32'h0000_6D40, 4'h4, 1'b1},
        '{32'h0000_6D80, 32'h0000_6D80, 4'h2, 1'b0},
        '{32'h0000_ED00, 32'h0000_ED00, 4'h1, 1'b1},
        '{32'hFFFF_6D1F, 32'h0000_6D00, 4'h0, 1'b1}
    };

    logic        clk;
    logic        rst;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wr;
    logic        rd;
    logic        wdt_lock;
    logic        ref_clk_in;
    logic        osc_clk_in;
    pplc_pwr_t   pwr;
    logic        pll_analog_en;
    logic        main_clk_out;
    logic        pll_lock;
    logic [2:0]  div_cnt;
    logic        ref_shift;
    int          mismatches;
    int          total_checks;
    int          hi;
    int          lo;
    int          bad;

    pplc_top #(.PART_CODE(TB_PART_CODE)) dut_u (
        .clk           (clk),
        .rst           (rst),
        .addr          (addr),
        .wdata         (wdata),
        .wr            (wr),
        .rd            (rd),
        .rdata         (rdata),
        .wdt_lock      (wdt_lock),
        .ref_clk_in    (ref_clk_in),
        .osc_clk_in    (osc_clk_in),
        .pwr           (pwr),
        .pll_analog_en (pll_analog_en),
        .main_clk_out  (main_clk_out),
        .pll_lock      (pll_lock)
    );

    always #50 clk = ~clk;

    // Oscillator and reference pins, period 8 clk; shift moves reference 2 clk early
    always @(posedge clk) begin
        div_cnt    <= div_cnt + 3'h1;
        osc_clk_in <= div_cnt[2];
        ref_clk_in <= ref_shift ? ((div_cnt + 3'h2) >= 3'h4) : div_cnt[2];
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic fail(input string msg);
        mismatches++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) fail($sformatf("%s: got %h exp %h", msg, got, exp));
    endtask

    task automatic chk_pwr(input logic [3:0] got, input logic [3:0] exp, input string msg);
        total_checks++;
        if (got !== exp) fail($sformatf("%s: got %b exp %b", msg, got, exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) fail($sformatf("%s: got %b exp %b", msg, got, exp));
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_word(rdata, exp, msg);
        tick();
        chk_word(rdata, 32'h0, "read data not cleared");
    endtask

    task automatic measure(output int h, output int l);
        int n;
        n = 0;
        h = 0;
        l = 0;
        while (main_clk_out !== 1'b0 && n < 600) begin
            tick();
            n++;
        end
        while (main_clk_out !== 1'b1 && n < 600) begin
            tick();
            n++;
        end
        while (main_clk_out === 1'b1 && n < 600) begin
            tick();
            n++;
            h++;
        end
        while (main_clk_out === 1'b0 && n < 600) begin
            tick();
            n++;
            l++;
        end
    endtask

    task automatic wait_lock(input logic exp, input int limit);
        int n;
        n = 0;
        while (pll_lock !== exp && n < limit) begin
            tick();
            n++;
        end
        chk_bit(pll_lock, exp, "lock level");
    endtask

    task automatic count_bad(input int cycles, input logic lock_exp);
        bad = 0;
        repeat (cycles) begin
            tick();
            if (pll_lock !== lock_exp) bad++;
        end
    endtask

    // Power up clear of a reference edge, then expect lock on the 9th match
    task automatic acquire;
        @(posedge ref_clk_in);
        repeat (3) @(posedge clk);
        reg_wr(CFG, 32'h0000_6D00);
        repeat (8) @(posedge ref_clk_in);
        #1;
        chk_bit(pll_lock, 1'b0, "lock after eight periods");
        wait_lock(1'b1, 60);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #1000000;
        fail("timeout");
        stop_test();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = 32'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        wdt_lock = 1'b0;
        ref_clk_in = 1'b0;
        osc_clk_in = 1'b0;
        div_cnt = 3'h0;
        ref_shift = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_pwr(pwr, 4'hF, "reset power bits");
        chk_bit(pll_analog_en, 1'b0, "reset analog enable");
        chk_bit(pll_lock, 1'b0, "reset lock");
        rd_chk(CFG, 32'h0000_EDE0, "reset config");
        rd_chk(PART_IDENTITY_ADDR, TB_PART_CODE, "identity");
        reg_wr(PART_IDENTITY_ADDR, ~TB_PART_CODE);
        rd_chk(PART_IDENTITY_ADDR, TB_PART_CODE, "identity after write");
        rd_chk(UNMAPPED_ADDR, 32'h0, "unmapped read");
        $display("test reset done");

        for (int i = 0; i < 6; i++) begin
            reg_wr(CFG, ROWS[i].wdata);
            chk_pwr(pwr, ROWS[i].pwr, "power bits");
            chk_bit(pll_analog_en, ROWS[i].en, "analog enable");
            rd_chk(CFG, ROWS[i].rd, "config readback");
        end
        $display("test table done");

        reg_wr(CFG, 32'h0000_6D40);
        @(posedge clk);
        wdt_lock <= 1'b1;
        tick();
        chk_pwr(pwr, 4'h0, "watchdog forced on");
        reg_wr(CFG, 32'h0000_6D00);
        reg_wr(CFG, 32'h0000_6D40);
        chk_pwr(pwr, 4'h0, "watchdog down under lock");
        rd_chk(CFG, 32'h0000_6D00, "watchdog bit dropped");
        @(posedge clk);
        wdt_lock <= 1'b0;
        tick();
        chk_pwr(pwr, 4'h0, "watchdog after unlock");
        $display("test watchdog done");

        for (int p = 0; p < 4; p++) begin
            reg_wr(CFG, 32'h0000_6D80);
            reg_wr(PLL_CONTROL_ADDR, 32'(p) << POST_SEL_POS);
            rd_chk(PLL_CONTROL_ADDR, 32'(p) << POST_SEL_POS, "post select read");
            reg_wr(CFG, 32'h0000_6D00);
            measure(hi, lo);
            chk_word(32'(hi), 32'(8 << p), "post divider high");
            chk_word(32'(lo), 32'(8 << p), "post divider low");
        end
        reg_wr(CFG, 32'h0000_6D80);
        reg_wr(PLL_CONTROL_ADDR, 32'h1 << BYPASS_BIT);
        reg_wr(CFG, 32'h0000_6D00);
        measure(hi, lo);
        chk_word(32'(hi + lo), 32'h8, "bypass period");
        chk_word(32'(hi), 32'(lo), "bypass duty");
        $display("test dividers done");

        reg_wr(CFG, 32'h0000_6D80);
        reg_wr(PLL_CONTROL_ADDR, (32'h1 << BYPASS_BIT) | 32'h1);
        reg_wr(CFG, 32'h0000_6D00);
        count_bad(200, 1'b0);
        chk_word(32'(bad), 32'h0, "lock with feedback of two");
        reg_wr(CFG, 32'h0000_6D80);
        reg_wr(PLL_CONTROL_ADDR, 32'h1 << BYPASS_BIT);
        acquire();
        count_bad(160, 1'b1);
        chk_word(32'(bad), 32'h0, "lock held");
        @(posedge clk);
        ref_shift <= 1'b1;
        wait_lock(1'b0, 20);
        @(posedge clk);
        ref_shift <= 1'b0;
        wait_lock(1'b1, 120);
        reg_wr(CFG, 32'h0000_6D80);
        wait_lock(1'b0, 2);
        chk_bit(pll_analog_en, 1'b0, "analog off in power down");
        repeat (2) tick();
        bad = 0;
        repeat (64) begin
            tick();
            if (pll_lock !== 1'b0 || main_clk_out !== 1'b0) bad++;
        end
        chk_word(32'(bad), 32'h0, "quiet in power down");
        acquire();
        $display("test lock done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_pwr(pwr, 4'hF, "power bits after second reset");
        chk_bit(pll_lock, 1'b0, "lock after second reset");
        chk_bit(main_clk_out, 1'b0, "main clock after second reset");
        rd_chk(CFG, 32'h0000_EDE0, "config after second reset");
        rd_chk(PLL_CONTROL_ADDR, 32'h0, "divider after second reset");
        $display("test second reset done");
        stop_test();
    end

endmodule
`default_nettype wire
